// ---- can_mbx_pkg.sv ----
package can_mbx_pkg;
	// ************************************************************
	// register map
	// ************************************************************
	localparam logic [7:0]  OFF_TRANSFER    = 8'h00;
	localparam logic [7:0]  OFF_ABORT       = 8'h04;
	localparam logic [7:0]  OFF_TIMER       = 8'h08;
	localparam logic [2:0]  BLK_CMD         = 3'h0;
	localparam logic [2:0]  BLK_MODE        = 3'h1;
	localparam logic [2:0]  BLK_MASK        = 3'h2;
	localparam logic [2:0]  BLK_ID          = 3'h3;
	localparam logic [2:0]  BLK_STATUS      = 3'h4;
	// ************************************************************
	// field positions
	// ************************************************************
	localparam int          TIMER_CLEAR_BIT = 31;
	localparam int          MARK_LSB        = 0;
	localparam int          PRIOR_LSB       = 16;
	localparam int          KIND_LSB        = 24;
	localparam int          IDE_BIT         = 29;
	localparam int          STD_LSB         = 18;
	localparam int          EXT_LSB         = 0;
	localparam int          ST_READY_BIT    = 23;
	localparam int          ST_ABORTED_BIT  = 22;
	localparam int          ST_PENDING_BIT  = 2;
	localparam int          ST_REMOTE_BIT   = 1;
	localparam int          ST_RTR_SEEN_BIT = 0;
	// ************************************************************
	// object kinds and reset values
	// ************************************************************
	localparam logic [2:0]  KIND_OFF        = 3'h0;
	localparam logic [2:0]  KIND_RX         = 3'h1;
	localparam logic [2:0]  KIND_RX_OVWR    = 3'h2;
	localparam logic [2:0]  KIND_TX         = 3'h3;
	localparam logic [2:0]  KIND_CONSUMER   = 3'h4;
	localparam logic [2:0]  KIND_PRODUCER   = 3'h5;
	localparam logic [31:0] MODE_RST        = 32'h0000_0000;
	localparam logic [31:0] MASK_RST        = 32'h0000_0000;
	localparam logic [31:0] ID_RST          = 32'h0000_0000;
	localparam logic [15:0] TIMER_RST       = 16'h0000;

	typedef struct packed {
		logic [2:0]  mailbox_object_kind;
		logic [3:0]  prior;
		logic [15:0] tx_window_mark;
	} mode_t;

	typedef struct packed {
		logic        extended_id_select;
		logic [10:0] standard_id_mask;
		logic [17:0] extended_id_ext_mask;
	} ident_t;

	typedef struct packed {
		logic        valid;
		logic        ide;
		logic        rtr;
		logic [28:0] id;
	} rx_frame_t;
endpackage

// ---- can_mailbox_command_config.sv ----
// Contract
// - one write requests transfer on bits 0..7
// - receive kinds arm for next message
// - transmit kind sends loaded data soon
// - consumer request sends a remote frame
// - producer answers only after remote frame
// - request clears ready and aborted flags; here a same-cycle ready set wins
// - pending sends by priority, then index
// - bit 31 clears the frame timer
// - timer clear also unfreezes the timer; here a same-cycle freeze wins
// - one write aborts; receive kinds ignore
// - transmit abort only before hand-over
// - consumer abort only before remote sent
// - producer abort drops next remote answer
// - time-triggered send waits for mark
// - mark reads zero in timestamp mode
// - receive kinds serviced lowest index first
// - kind per mailbox; zero disables it
// - full plain receiver discards new messages
// - overwrite receiver replaces stored message
// - consumer sends remote, then receives data
// - producer waits for remote before sending
// - extended select widens id comparison
//
// Chosen here: the plain strobed port and the address map.
`timescale 1ns/10ps
module can_mailbox_command_config #(
	parameter int N_MBX = 8
) (
	input  wire logic                    ref_clk_in,
	input  wire logic                    resetn_in,
	input  wire logic                    clk_en_in,
	input  wire logic [7:0]              addr_in,
	input  wire logic [31:0]             wdata_in,
	input  wire logic                    wr_in,
	input  wire logic                    rd_in,
	output logic      [31:0]             rdata_out,
	input  wire logic                    tt_mode_in,
	input  wire logic                    timer_tick_in,
	input  wire logic                    timer_freeze_in,
	input  wire can_mbx_pkg::rx_frame_t  rx_frame_in,
	input  wire logic                    tx_start_in,
	input  wire logic                    tx_done_in,
	output logic                         tx_valid_out,
	output logic      [2:0]              tx_mbx_out,
	output logic                         tx_remote_out,
	output logic                         rx_hit_out,
	output logic      [2:0]              rx_mbx_out,
	output logic      [N_MBX-1:0]        mbx_ready_out,
	output logic      [15:0]             timer_out
);
	typedef enum logic [1:0] {TX_IDLE, TX_OFFER, TX_SEND} tx_state_t;

	// ************************************************************
	// helpers
	// ************************************************************
	function automatic logic [2:0] eff_kind(input logic [2:0] k);
		// reserved
		eff_kind = (k[2] && k[1]) ? can_mbx_pkg::KIND_OFF : k;
	endfunction

	function automatic logic id_match(input can_mbx_pkg::ident_t id,
		input can_mbx_pkg::ident_t msk, input can_mbx_pkg::rx_frame_t f);
		logic std_ok;
		logic ext_ok;
		std_ok = (((f.id[28:18] ^ id.standard_id_mask) & msk.standard_id_mask) == 11'h000);
		ext_ok = (((f.id[17:0] ^ id.extended_id_ext_mask) & msk.extended_id_ext_mask)
			== 18'h00000);
		id_match = (f.ide == id.extended_id_select) && std_ok
			&& (!msk.extended_id_select || ext_ok);
	endfunction

	can_mbx_pkg::mode_t  mode_reg     [N_MBX];
	can_mbx_pkg::mode_t  mode_next    [N_MBX];
	can_mbx_pkg::ident_t mask_reg     [N_MBX];
	can_mbx_pkg::ident_t mask_next    [N_MBX];
	can_mbx_pkg::ident_t id_reg       [N_MBX];
	can_mbx_pkg::ident_t id_next      [N_MBX];
	logic [N_MBX-1:0]    pending_reg;
	logic [N_MBX-1:0]    pending_next;
	logic [N_MBX-1:0]    ready_reg;
	logic [N_MBX-1:0]    ready_next;
	logic [N_MBX-1:0]    aborted_reg;
	logic [N_MBX-1:0]    aborted_next;
	logic [N_MBX-1:0]    remote_sent_reg;
	logic [N_MBX-1:0]    remote_sent_next;
	logic [N_MBX-1:0]    rtr_seen_reg;
	logic [N_MBX-1:0]    rtr_seen_next;
	logic [15:0]         timer_reg;
	logic [15:0]         timer_next;
	logic                frozen_reg;
	logic                frozen_next;
	tx_state_t           state_reg;
	tx_state_t           state_next;
	logic [2:0]          sel_reg;
	logic [2:0]          sel_next;
	logic                remote_reg;
	logic                remote_next;
	logic                rx_hit_reg;
	logic                rx_hit_next;
	logic [2:0]          rx_mbx_reg;
	logic [2:0]          rx_mbx_next;
	logic [31:0]         rdata_reg;
	logic [31:0]         rdata_next;
	logic [2:0]          kind        [N_MBX];
	logic [15:0]         mark_eff    [N_MBX];
	logic [N_MBX-1:0]    cand;
	logic [N_MBX-1:0]    rx_hits;
	logic [N_MBX-1:0]    ready_set;
	logic [2:0]          best;
	logic                wr_xfer;
	logic                wr_abort;
	logic                locked;
	logic [2:0]          blk;
	logic [2:0]          idx;

	// ************************************************************
	// candidates and arbitration
	// ************************************************************
	always_comb
	begin
		best = 3'h0;
		for (int i = 0; i < N_MBX; i++)
		begin
			kind[i] = eff_kind(mode_reg[i].mailbox_object_kind);
			mark_eff[i] = tt_mode_in ? mode_reg[i].tx_window_mark : can_mbx_pkg::TIMER_RST;
			cand[i] = pending_reg[i] && (timer_reg >= mark_eff[i])
				&& ((kind[i] == can_mbx_pkg::KIND_TX)
				|| (kind[i] == can_mbx_pkg::KIND_CONSUMER && !remote_sent_reg[i])
				|| (kind[i] == can_mbx_pkg::KIND_PRODUCER && rtr_seen_reg[i]));
			rx_hits[i] = rx_frame_in.valid && id_match(id_reg[i], mask_reg[i], rx_frame_in)
				&& ((!rx_frame_in.rtr && pending_reg[i]
				&& (kind[i] == can_mbx_pkg::KIND_RX || kind[i] == can_mbx_pkg::KIND_RX_OVWR))
				|| (!rx_frame_in.rtr && pending_reg[i] && remote_sent_reg[i]
				&& kind[i] == can_mbx_pkg::KIND_CONSUMER)
				|| (rx_frame_in.rtr && pending_reg[i] && kind[i] == can_mbx_pkg::KIND_PRODUCER));
		end
		for (int i = N_MBX - 1; i >= 0; i--)
		begin
			if (cand[i] && (!cand[best] || mode_reg[i].prior <= mode_reg[best].prior))
			begin
				best = i[2:0];
			end
		end
	end

	// ************************************************************
	// next state
	// ************************************************************
	always_comb
	begin
		mode_next        = mode_reg;
		mask_next        = mask_reg;
		id_next          = id_reg;
		pending_next     = pending_reg;
		ready_next       = ready_reg;
		aborted_next     = aborted_reg;
		remote_sent_next = remote_sent_reg;
		rtr_seen_next    = rtr_seen_reg;
		timer_next       = timer_reg;
		frozen_next      = frozen_reg;
		state_next       = state_reg;
		sel_next         = sel_reg;
		remote_next      = remote_reg;
		rx_hit_next      = 1'b0;
		rx_mbx_next      = rx_mbx_reg;
		rdata_next       = rdata_reg;
		ready_set        = '0;
		blk              = addr_in[7:5];
		idx              = addr_in[4:2];
		wr_xfer          = wr_in && (addr_in == can_mbx_pkg::OFF_TRANSFER);
		wr_abort         = wr_in && (addr_in == can_mbx_pkg::OFF_ABORT);
		locked           = (state_reg == TX_SEND);

		if (wr_in && blk == can_mbx_pkg::BLK_MODE)
		begin
			mode_next[idx]        = can_mbx_pkg::mode_t'({wdata_in[26:24],
				wdata_in[19:16], wdata_in[15:0]});
			pending_next[idx]     = 1'b0;
			remote_sent_next[idx] = 1'b0;
			rtr_seen_next[idx]    = 1'b0;
		end
		// software keeps the mailbox off meanwhile
		if (wr_in && blk == can_mbx_pkg::BLK_MASK)
		begin
			mask_next[idx] = can_mbx_pkg::ident_t'(wdata_in[29:0]);
		end
		if (wr_in && blk == can_mbx_pkg::BLK_ID)
		begin
			id_next[idx] = can_mbx_pkg::ident_t'(wdata_in[29:0]);
		end

		for (int i = 0; i < N_MBX; i++)
		begin
			if (wr_xfer && wdata_in[i] && kind[i] != can_mbx_pkg::KIND_OFF
				&& !(locked && sel_reg == i[2:0]))
			begin
				pending_next[i]     = 1'b1;
				remote_sent_next[i] = 1'b0;
				rtr_seen_next[i]    = 1'b0;
			end
			if (wr_xfer && wdata_in[i])
			begin
				ready_next[i]   = 1'b0;
				aborted_next[i] = 1'b0;
			end
			if (wr_abort && wdata_in[i] && pending_reg[i] && !(locked && sel_reg == i[2:0])
				&& (kind[i] == can_mbx_pkg::KIND_TX || kind[i] == can_mbx_pkg::KIND_PRODUCER
				|| (kind[i] == can_mbx_pkg::KIND_CONSUMER && !remote_sent_reg[i])))
			begin
				pending_next[i]  = 1'b0;
				rtr_seen_next[i] = 1'b0;
				aborted_next[i]  = 1'b1;
			end
		end

		for (int i = N_MBX - 1; i >= 0; i--)
		begin
			if (rx_hits[i])
			begin
				rx_mbx_next = i[2:0];
			end
		end
		if (rx_hits != '0)
		begin
			if (kind[rx_mbx_next] == can_mbx_pkg::KIND_PRODUCER)
			begin
				rtr_seen_next[rx_mbx_next] = 1'b1;
			end
			else
			begin
				rx_hit_next = 1'b1;
				ready_set[rx_mbx_next] = 1'b1;
				// plain receiver stops after one message
				if (kind[rx_mbx_next] != can_mbx_pkg::KIND_RX_OVWR)
				begin
					pending_next[rx_mbx_next] = 1'b0;
				end
			end
		end

		unique case (state_reg)
			TX_IDLE:
			begin
				if (cand != '0)
				begin
					sel_next    = best;
					remote_next = (kind[best] == can_mbx_pkg::KIND_CONSUMER);
					state_next  = TX_OFFER;
				end
			end
			TX_OFFER:
			begin
				if (!cand[sel_reg] || !pending_next[sel_reg])
				begin
					state_next = TX_IDLE;
				end
				else if (tx_start_in)
				begin
					state_next = TX_SEND;
				end
			end
			TX_SEND:
			begin
				if (tx_done_in)
				begin
					state_next = TX_IDLE;
					if (remote_reg)
					begin
						remote_sent_next[sel_reg] = 1'b1;
					end
					else
					begin
						pending_next[sel_reg]  = 1'b0;
						rtr_seen_next[sel_reg] = 1'b0;
						ready_set[sel_reg]     = 1'b1;
					end
				end
			end
		endcase
		// hardware set wins over a same-cycle clear
		ready_next = ready_next | ready_set;

		if (wr_xfer && wdata_in[can_mbx_pkg::TIMER_CLEAR_BIT])
		begin
			timer_next  = can_mbx_pkg::TIMER_RST;
			frozen_next = 1'b0;
		end
		else if (timer_tick_in && !frozen_reg)
		begin
			timer_next = timer_reg + 16'h0001;
		end
		if (timer_freeze_in)
		begin
			frozen_next = 1'b1;
		end

		if (rd_in)
		begin
			rdata_next = 32'h0000_0000;
			unique case (blk)
				can_mbx_pkg::BLK_CMD:
					if (addr_in == can_mbx_pkg::OFF_TIMER)
					begin
						rdata_next[15:0] = timer_reg;
					end
				can_mbx_pkg::BLK_MODE:
				begin
					rdata_next[can_mbx_pkg::KIND_LSB +: 3] = mode_reg[idx].mailbox_object_kind;
					rdata_next[can_mbx_pkg::PRIOR_LSB +: 4] = mode_reg[idx].prior;
					rdata_next[can_mbx_pkg::MARK_LSB +: 16] = mark_eff[idx];
				end
				can_mbx_pkg::BLK_MASK:
					rdata_next[29:0] = mask_reg[idx];
				can_mbx_pkg::BLK_ID:
					rdata_next[29:0] = id_reg[idx];
				can_mbx_pkg::BLK_STATUS:
				begin
					rdata_next[can_mbx_pkg::ST_READY_BIT]    = ready_reg[idx];
					rdata_next[can_mbx_pkg::ST_ABORTED_BIT]  = aborted_reg[idx];
					rdata_next[can_mbx_pkg::ST_PENDING_BIT]  = pending_reg[idx];
					rdata_next[can_mbx_pkg::ST_REMOTE_BIT]   = remote_sent_reg[idx];
					rdata_next[can_mbx_pkg::ST_RTR_SEEN_BIT] = rtr_seen_reg[idx];
				end
				default:
					rdata_next = 32'h0000_0000;
			endcase
		end
	end

	// ************************************************************
	// registers
	// ************************************************************
	always_ff @(posedge ref_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			for (int i = 0; i < N_MBX; i++)
			begin
				mode_reg[i] <= can_mbx_pkg::mode_t'(can_mbx_pkg::MODE_RST[22:0]);
				mask_reg[i] <= can_mbx_pkg::ident_t'(can_mbx_pkg::MASK_RST[29:0]);
				id_reg[i]   <= can_mbx_pkg::ident_t'(can_mbx_pkg::ID_RST[29:0]);
			end
			pending_reg     <= '0;
			ready_reg       <= '0;
			aborted_reg     <= '0;
			remote_sent_reg <= '0;
			rtr_seen_reg    <= '0;
			timer_reg       <= can_mbx_pkg::TIMER_RST;
			frozen_reg      <= 1'b0;
			state_reg       <= TX_IDLE;
			sel_reg         <= 3'h0;
			remote_reg      <= 1'b0;
			rx_hit_reg      <= 1'b0;
			rx_mbx_reg      <= 3'h0;
			rdata_reg       <= 32'h0000_0000;
		end
		else if (clk_en_in)
		begin
			mode_reg        <= mode_next;
			mask_reg        <= mask_next;
			id_reg          <= id_next;
			pending_reg     <= pending_next;
			ready_reg       <= ready_next;
			aborted_reg     <= aborted_next;
			remote_sent_reg <= remote_sent_next;
			rtr_seen_reg    <= rtr_seen_next;
			timer_reg       <= timer_next;
			frozen_reg      <= frozen_next;
			state_reg       <= state_next;
			sel_reg         <= sel_next;
			remote_reg      <= remote_next;
			rx_hit_reg      <= rx_hit_next;
			rx_mbx_reg      <= rx_mbx_next;
			rdata_reg       <= rdata_next;
		end
	end

	assign rdata_out     = rdata_reg;
	assign tx_valid_out  = (state_reg == TX_OFFER);
	assign tx_mbx_out    = sel_reg;
	assign tx_remote_out = remote_reg;
	assign rx_hit_out    = rx_hit_reg;
	assign rx_mbx_out    = rx_mbx_reg;
	assign mbx_ready_out = ready_reg;
	assign timer_out     = timer_reg;

	// ************************************************************
	// checks
	// ************************************************************
	logic [N_MBX-1:0] cand_d_reg;
	logic [N_MBX-1:0] beats;
	always_ff @(posedge ref_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
			cand_d_reg <= '0;
		else if (clk_en_in)
			cand_d_reg <= cand;
	end
	always_comb
	begin
		for (int j = 0; j < N_MBX; j++)
			beats[j] = cand_d_reg[j] && ((mode_reg[j].prior < mode_reg[sel_reg].prior)
				|| (mode_reg[j].prior == mode_reg[sel_reg].prior && j[2:0] < sel_reg));
	end

	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!resetn_in);

	sequence s_clear_cmd;
		clk_en_in && wr_xfer && wdata_in[can_mbx_pkg::TIMER_CLEAR_BIT];
	endsequence
	property p_req_clears;
		clk_en_in && wr_xfer && wdata_in[0] && !ready_set[0] |=> !ready_reg[0] && !aborted_reg[0];
	endproperty
	a_req_clears: assert property (p_req_clears) else $error("request left flags set");
	property p_timer_clear;
		s_clear_cmd |=> timer_reg == 16'h0000;
	endproperty
	a_timer_clear: assert property (p_timer_clear) else $error("timer not cleared");
	property p_timer_restart;
		s_clear_cmd ##0 !timer_freeze_in |=> !frozen_reg;
	endproperty
	a_timer_restart: assert property (p_timer_restart) else $error("timer still frozen");
	property p_rx_no_abort;
		clk_en_in && wr_abort && wdata_in[0] && kind[0] == can_mbx_pkg::KIND_RX
			|=> aborted_reg[0] == $past(aborted_reg[0]);
	endproperty
	a_rx_no_abort: assert property (p_rx_no_abort) else $error("receiver took abort");
	property p_order;
		clk_en_in && state_reg == TX_IDLE && cand != '0 |=> beats == '0;
	endproperty
	a_order: assert property (p_order) else $error("wrong mailbox offered");
	property p_locked;
		clk_en_in && locked && sel_reg == 3'h0 && wr_abort && wdata_in[0] && !tx_done_in
			|=> pending_reg[0] && !aborted_reg[0];
	endproperty
	a_locked: assert property (p_locked) else $error("abort after hand-over");
	property p_discard;
		clk_en_in && rx_frame_in.valid && kind[0] == can_mbx_pkg::KIND_RX && !pending_reg[0]
			|=> !(rx_hit_out && rx_mbx_out == 3'h0);
	endproperty
	a_discard: assert property (p_discard) else $error("full receiver accepted");
	property p_overwrite;
		clk_en_in && rx_hits[0] && kind[0] == can_mbx_pkg::KIND_RX_OVWR
			|=> rx_hit_out && rx_mbx_out == 3'h0 ##1 pending_reg[0] || !clk_en_in;
	endproperty
	a_overwrite: assert property (p_overwrite) else $error("overwrite not taken");
	property p_disabled;
		mode_reg[0].mailbox_object_kind[2:1] == 2'b11 |-> !cand[0] && !rx_hits[0];
	endproperty
	a_disabled: assert property (p_disabled) else $error("reserved kind active");
	property p_mark;
		clk_en_in && state_reg == TX_IDLE && cand != '0 && tt_mode_in
			|-> timer_reg >= mode_reg[best].tx_window_mark;
	endproperty
	a_mark: assert property (p_mark) else $error("sent before mark");
endmodule

// ---- can_bus_node_model.sv ----
`timescale 1ns/10ps
module can_bus_node_model (
	input  wire logic                   clk_in,
	input  wire logic                   resetn_in,
	input  wire logic                   serve_in,
	input  wire logic [3:0]             delay_in,
	input  wire logic                   tx_valid_in,
	input  wire logic [2:0]             tx_mbx_in,
	input  wire logic                   send_in,
	input  wire can_mbx_pkg::rx_frame_t frame_in,
	output logic                        tx_start_out,
	output logic                        tx_done_out,
	output can_mbx_pkg::rx_frame_t      rx_frame_out,
	output logic [2:0]                  last_mbx_out
);
	logic       busy_reg;
	logic [3:0] cnt_reg;

	always_ff @(posedge clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			busy_reg     <= 1'b0;
			cnt_reg      <= 4'h0;
			tx_start_out <= 1'b0;
			tx_done_out  <= 1'b0;
			rx_frame_out <= '0;
			last_mbx_out <= 3'h0;
		end
		else
		begin
			tx_start_out <= 1'b0;
			tx_done_out  <= 1'b0;
			// idle lines keep changing so no stale frame survives
			rx_frame_out <= send_in ? frame_in : {1'b0, ~rx_frame_out[30:0]};
			if (busy_reg)
			begin
				cnt_reg <= cnt_reg + 4'h1;
				if (cnt_reg == delay_in)
				begin
					tx_done_out <= 1'b1;
					busy_reg    <= 1'b0;
					cnt_reg     <= 4'h0;
				end
			end
			else if (serve_in && tx_valid_in && !tx_start_out)
			begin
				cnt_reg <= cnt_reg + 4'h1;
				if (cnt_reg == delay_in)
				begin
					tx_start_out <= 1'b1;
					busy_reg     <= 1'b1;
					last_mbx_out <= tx_mbx_in;
					cnt_reg      <= 4'h0;
				end
			end
			else
				cnt_reg <= 4'h0;
		end
	end
endmodule

// ---- can_mailbox_command_config_tb_top.sv ----
`timescale 1ns/10ps
module can_mailbox_command_config_tb_top;
	logic                   clk;
	logic                   rstn;
	logic                   en;
	logic [7:0]             addr;
	logic [31:0]            wdata;
	logic                   wr_s;
	logic                   rd_s;
	logic [31:0]            rdata;
	logic                   tt;
	logic                   tick;
	logic                   frz;
	can_mbx_pkg::rx_frame_t rxf;
	can_mbx_pkg::rx_frame_t frame;
	logic                   send;
	logic                   serve;
	logic [3:0]             dly;
	logic                   tx_start;
	logic                   tx_done;
	logic                   tx_valid;
	logic [2:0]             tx_mbx;
	logic                   tx_remote;
	logic                   rx_hit;
	logic [2:0]             rx_mbx;
	logic [7:0]             ready;
	logic [15:0]            timer;
	logic [2:0]             last_mbx;
	logic [2:0]             sigs;
	logic [31:0]            st;
	logic                   hit;
	int                     error_cnt;
	int                     comparisons;

	assign sigs = {tx_done, tx_start, tx_valid};

	can_mailbox_command_config can_mailbox_command_config_i (
		.ref_clk_in(clk), .resetn_in(rstn), .clk_en_in(en), .addr_in(addr),
		.wdata_in(wdata), .wr_in(wr_s), .rd_in(rd_s), .rdata_out(rdata),
		.tt_mode_in(tt), .timer_tick_in(tick), .timer_freeze_in(frz),
		.rx_frame_in(rxf), .tx_start_in(tx_start), .tx_done_in(tx_done),
		.tx_valid_out(tx_valid), .tx_mbx_out(tx_mbx), .tx_remote_out(tx_remote),
		.rx_hit_out(rx_hit), .rx_mbx_out(rx_mbx), .mbx_ready_out(ready),
		.timer_out(timer));

	can_bus_node_model can_bus_node_model_i (
		.clk_in(clk), .resetn_in(rstn), .serve_in(serve), .delay_in(dly),
		.tx_valid_in(tx_valid), .tx_mbx_in(tx_mbx), .send_in(send),
		.frame_in(frame), .tx_start_out(tx_start), .tx_done_out(tx_done),
		.rx_frame_out(rxf), .last_mbx_out(last_mbx));

	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// ****************
	// bus and checks
	// ****************
	function automatic logic [31:0] mw(logic [2:0] k, logic [3:0] p, logic [15:0] m);
		return {5'h00, k, 4'h0, p, m};
	endfunction

	function automatic logic [31:0] iw(logic [10:0] s);
		return {3'h0, s, 18'h00000};
	endfunction

	function automatic logic [7:0] ra(logic [7:0] b, int i);
		return b + 8'(4 * i);
	endfunction

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e)
		begin
			error_cnt++;
			$display("BAD %0t seen %h expected %h", $time, s, e);
		end
	endtask

	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic wait_sig(input int w);
		for (int i = 0; i < 300; i++)
		begin
			if (sigs[w] === 1'b1)
				return;
			@(posedge clk);
			#1;
		end
		error_cnt++;
		$display("BAD %0t wait ran out", $time);
		end_of_test();
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		wr_s  <= 1'b1;
		addr  <= a;
		wdata <= d;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		rd_s <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd_s <= 1'b0;
		#1 d = rdata;
	endtask

	task automatic cfg(input int i, input logic [2:0] k, input logic [15:0] m,
		input logic [10:0] s);
		wr(ra(8'h20, i), 32'h0);
		wr(ra(8'h40, i), iw(11'h7ff));
		wr(ra(8'h60, i), iw(s));
		wr(ra(8'h20, i), mw(k, 4'h0, m));
	endtask

	task automatic ticks(input int n);
		@(posedge clk);
		tick <= 1'b1;
		repeat (n) @(posedge clk);
		tick <= 1'b0;
		#1;
	endtask

	task automatic rx_send(input logic r, input logic [10:0] s);
		@(posedge clk);
		send  <= 1'b1;
		frame <= {1'b1, 1'b0, r, s, 18'h00000};
		@(posedge clk);
		send <= 1'b0;
		@(posedge clk);
		#1 hit = rx_hit;
	endtask

	// ****************
	// scenarios
	// ****************
	task automatic t_regs();
		rd(8'h20, st);
		chk(st, can_mbx_pkg::MODE_RST);
		rd(8'h40, st);
		chk(st, can_mbx_pkg::MASK_RST);
		wr(8'hfc, 32'hffff_ffff);
		rd(8'hfc, st);
		chk(st, 32'h0);
		$display("test regs done");
	endtask

	task automatic t_prio();
		logic [2:0] ord [4] = '{3'h3, 3'h1, 3'h2, 3'h0};
		dly <= 4'h2;
		for (int i = 0; i < 4; i++)
			cfg(i, can_mbx_pkg::KIND_TX, 16'h0, 11'h001);
		wr(8'h20, mw(can_mbx_pkg::KIND_TX, 4'h2, 16'h0));
		wr(8'h24, mw(can_mbx_pkg::KIND_TX, 4'h1, 16'h0));
		wr(8'h28, mw(can_mbx_pkg::KIND_TX, 4'h1, 16'h0));
		wr(8'h00, 32'h0000_000f);
		serve <= 1'b1;
		foreach (ord[k])
		begin
			wait_sig(2);
			chk(32'(last_mbx), 32'(ord[k]));
			@(posedge clk);
			#1;
		end
		chk(32'(ready[3:0]), 32'hf);
		serve <= 1'b0;
		wr(8'h00, 32'h1);
		#1 chk(32'(ready[0]), 32'h0);
		$display("test prio done");
	endtask

	task automatic t_abort();
		cfg(4, can_mbx_pkg::KIND_RX, 16'h0, 11'h0aa);
		wr(8'h00, 32'h10);
		wr(8'h04, 32'h11);
		rd(8'h80, st);
		chk(32'({st[22], st[2], tx_valid}), 32'h4);
		rd(8'h90, st);
		chk(32'({st[22], st[2]}), 32'h1);
		wr(8'h00, 32'h1);
		rd(8'h80, st);
		chk(32'(st[22]), 32'h0);
		dly   <= 4'h8;
		serve <= 1'b1;
		wait_sig(1);
		wr(8'h04, 32'h1);
		wait_sig(2);
		@(posedge clk);
		rd(8'h80, st);
		chk(st, 32'h0080_0000);
		$display("test abort done");
	endtask

	task automatic t_timer();
		wr(8'h00, 32'h8000_0000);
		#1 chk(32'(timer), 32'h0);
		ticks(5);
		@(posedge clk);
		frz <= 1'b1;
		@(posedge clk);
		frz <= 1'b0;
		ticks(3);
		chk(32'(timer), 32'h5);
		wr(8'h00, 32'h8000_0000);
		ticks(2);
		rd(8'h08, st);
		chk(st, 32'h2);
		$display("test timer done");
	endtask

	task automatic t_mark();
		tt  <= 1'b1;
		dly <= 4'h0;
		cfg(5, can_mbx_pkg::KIND_TX, 16'h0006, 11'h005);
		wr(8'h00, 32'h8000_0020);
		ticks(5);
		repeat (4) @(posedge clk);
		#1 chk(32'(tx_valid), 32'h0);
		ticks(1);
		wait_sig(2);
		chk(32'(last_mbx), 32'h5);
		rd(8'h34, st);
		chk(st, mw(can_mbx_pkg::KIND_TX, 4'h0, 16'h0006));
		tt <= 1'b0;
		rd(8'h34, st);
		chk(st, mw(can_mbx_pkg::KIND_TX, 4'h0, 16'h0));
		$display("test mark done");
	endtask

	task automatic t_cons();
		serve <= 1'b0;
		cfg(6, can_mbx_pkg::KIND_CONSUMER, 16'h0, 11'h123);
		wr(8'h00, 32'h40);
		wait_sig(0);
		chk(32'({tx_remote, tx_mbx}), 32'he);
		wr(8'h04, 32'h40);
		rd(8'h98, st);
		chk(32'({st[22], tx_valid}), 32'h2);
		wr(8'h00, 32'h40);
		serve <= 1'b1;
		wait_sig(2);
		@(posedge clk);
		rd(8'h98, st);
		chk(32'({st[23], st[2:1]}), 32'h3);
		rx_send(1'b0, 11'h123);
		chk(32'({hit, rx_mbx, ready[6]}), 32'h1d);
		$display("test consumer done");
	endtask

	task automatic t_prod();
		cfg(7, can_mbx_pkg::KIND_PRODUCER, 16'h0, 11'h055);
		wr(8'h00, 32'h80);
		repeat (10) @(posedge clk);
		#1 chk(32'(tx_valid), 32'h0);
		rx_send(1'b1, 11'h055);
		wait_sig(2);
		chk(32'(last_mbx), 32'h7);
		@(posedge clk);
		wr(8'h00, 32'h80);
		wr(8'h04, 32'h80);
		rx_send(1'b1, 11'h055);
		repeat (10) @(posedge clk);
		rd(8'h9c, st);
		chk(32'({st[22], tx_valid, ready[7]}), 32'h4);
		$display("test producer done");
	endtask

	task automatic t_rx();
		cfg(1, can_mbx_pkg::KIND_OFF, 16'h0, 11'h0aa);
		cfg(2, 3'h6, 16'h0, 11'h0aa);
		cfg(3, can_mbx_pkg::KIND_RX, 16'h0, 11'h0aa);
		cfg(4, can_mbx_pkg::KIND_RX_OVWR, 16'h0, 11'h0aa);
		rx_send(1'b0, 11'h0aa);
		chk(32'(hit), 32'h0);
		wr(8'h00, 32'h1e);
		rx_send(1'b0, 11'h0aa);
		chk(32'({hit, rx_mbx}), 32'hb);
		rx_send(1'b0, 11'h0aa);
		chk(32'({hit, rx_mbx}), 32'hc);
		rx_send(1'b0, 11'h0aa);
		chk(32'({hit, rx_mbx, ready[4:3]}), 32'h33);
		$display("test receive done");
	endtask

	initial
	begin
		rstn        = 1'b0;
		en          = 1'b1;
		addr        = 8'h00;
		wdata       = 32'h0;
		wr_s        = 1'b0;
		rd_s        = 1'b0;
		tt          = 1'b0;
		tick        = 1'b0;
		frz         = 1'b0;
		send        = 1'b0;
		frame       = '0;
		serve       = 1'b0;
		dly         = 4'h0;
		error_cnt   = 0;
		comparisons = 0;
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		t_regs();
		t_prio();
		t_abort();
		t_timer();
		t_mark();
		t_cons();
		t_prod();
		t_rx();
		end_of_test();
	end
endmodule
